// *** logic/ite_defines.vh ***
// Purpose: constants for the interrupt driven transfer engine
// Assumes: included by ite_engine.v and by the bench
// Notes: register indices are word indices, byte address is four times
//
// Operation
// - start on enabled interrupt activation or on software activation
// - source address mode: fixed, increment or decrement by size
// - destination address mode behaves like source mode
// - mode field picks normal, repeat or block transfer
// - area side bit puts repeat or block area on source or destination
// - size bit picks byte or word transfers
// - chain bit set: fetch next descriptor, transfer again same activation
// - chain bit clear: finish and wait for new activation
// - chained transfer skips end check, flag clear and enable clear
// - select bit clear: clear source flag unless count reached zero
// - select bit set: leave source flag set after every transfer
// - low six bits of second mode byte ignored, written back unchanged
// - source and destination addresses are 24 bits wide
// - descriptor read and write back over 32 bits, one state each
// - descriptors live only in ram window f800 to fbff
// - mode, address and count registers not reachable by software
// - registers reachable after reset; module stop halts the engine
// - normal mode: 16 bit count decrements, ends at zero
// - repeat or block: low count byte decrements, reloads from high byte
// - enable bit cleared when select bit set or all transfers ended
// - block mode: block count decrements per block, ends at zero
`ifndef ITE_DEFINES_VH
`define ITE_DEFINES_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define ITE_IDX_EN0 16'hff30
`define ITE_IDX_EN4 16'hff34
`define ITE_IDX_VEC 16'hff37
`define ITE_IDX_STS 16'hff38
`define ITE_IDX_MSTP 16'hff3c

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define ITE_EN_RST 40'h00_0000_0000
`define ITE_VEC_RST 8'h00
`define ITE_MSTP_RST 16'h3fff
`define ITE_MSTP_BIT 14
`define ITE_VEC_SWE 7
`define ITE_MA_SM1 7
`define ITE_MA_SM0 6
`define ITE_MA_DM1 5
`define ITE_MA_DM0 4
`define ITE_MA_MDH 3
`define ITE_MA_MDL 2
`define ITE_MA_SIDE 1
`define ITE_MA_SZ 0
`define ITE_MB_CHN 7
`define ITE_MB_SEL 6
`define ITE_MD_NORM 2'b00
`define ITE_MD_REP 2'b01
`define ITE_MD_BLK 2'b10

// ----------------------------------------------------------------
// descriptor window
// ----------------------------------------------------------------
`define ITE_RAM_BASE 16'hf800
`define ITE_RAM_MASK 16'h03ff
`define ITE_DESC_STRIDE 16'h0010
`define ITE_WORD_STEP 16'h0004

`endif

// *** logic/ite_engine.v ***
// Purpose: interrupt or software activated transfer engine
// Assumes: one 20 MHz clock, synchronous descriptor ram, bus arbiter ack
// Notes: registers on an ahb-lite slave, reads take one wait state
`timescale 1ns/1ps
`default_nettype none
`include "ite_defines.vh"

module ite_engine #(
  parameter NSRC = 40
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [NSRC-1:0] irq_req,
  output wire flag_clr,
  output wire [5:0] flag_clr_id,
  output wire ram_en,
  output wire ram_we,
  output wire [15:0] ram_addr,
  output wire [31:0] ram_wdata,
  input wire [31:0] ram_rdata,
  output wire bus_req,
  output wire bus_we,
  output wire bus_size,
  output wire [23:0] bus_addr,
  output wire [15:0] bus_wdata,
  input wire [15:0] bus_rdata,
  input wire bus_ack
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'd0;
  localparam S_RA = 4'd1;
  localparam S_RB = 4'd2;
  localparam S_RC = 4'd3;
  localparam S_RD = 4'd4;
  localparam S_XR = 4'd5;
  localparam S_XW = 4'd6;
  localparam S_WA = 4'd7;
  localparam S_WB = 4'd8;
  localparam S_WC = 4'd9;
  localparam S_FIN = 4'd10;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // lowest numbered enabled source wins
  function [6:0] ite_pick;
    input [NSRC-1:0] p;
    integer i;
    begin
      ite_pick = 7'h00;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (p[i]) begin
          ite_pick = {1'b1, i[5:0]};
        end
      end
    end
  endfunction

  function [23:0] ite_adv;
    input [23:0] a;
    input [1:0] m;
    input sz;
    begin
      if (!m[1]) begin
        ite_adv = a;
      end else if (m[0]) begin
        ite_adv = a - {22'h000000, sz, ~sz};
      end else begin
        ite_adv = a + {22'h000000, sz, ~sz};
      end
    end
  endfunction

  // undo one full pass of n units, n of zero meaning 256
  function [23:0] ite_rew;
    input [23:0] a;
    input [1:0] m;
    input sz;
    input [7:0] n;
    reg [9:0] span;
    begin
      span = sz ? {(n == 8'h00), n, 1'b0} : {1'b0, (n == 8'h00), n};
      if (!m[1]) begin
        ite_rew = a;
      end else if (m[0]) begin
        ite_rew = a + {14'h0000, span};
      end else begin
        ite_rew = a - {14'h0000, span};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [NSRC-1:0] en_ff;
  reg [7:0] vec_ff;
  reg arm_ff;
  reg [15:0] mstp_ff;
  reg wr_ff;
  reg rd_ff;
  reg aok_ff;
  reg [15:0] aidx_ff;
  reg [31:0] hrdata_ff;
  reg [7:0] mra_ff;
  reg [7:0] mrb_ff;
  reg [23:0] sar_ff;
  reg [23:0] dar_ff;
  reg [15:0] cra_ff;
  reg [15:0] crb_ff;
  reg [15:0] dbase_ff;
  reg [5:0] src_ff;
  reg sw_ff;
  reg [15:0] data_ff;
  reg [15:0] ram_addr_ff;
  reg [31:0] ram_wdata_ff;
  reg flag_clr_ff;
  reg [5:0] flag_id_ff;
  reg en_clr;
  reg sw_clr;
  reg [23:0] nxt_sar;
  reg [23:0] nxt_dar;
  reg [15:0] nxt_cra;
  reg [15:0] nxt_crb;
  reg blk_more;

  wire stop = mstp_ff[`ITE_MSTP_BIT];
  wire [6:0] pick = ite_pick(irq_req & en_ff);
  wire [1:0] md = {mra_ff[`ITE_MA_MDH], mra_ff[`ITE_MA_MDL]};
  wire [1:0] sm = {mra_ff[`ITE_MA_SM1], mra_ff[`ITE_MA_SM0]};
  wire [1:0] dm = {mra_ff[`ITE_MA_DM1], mra_ff[`ITE_MA_DM0]};
  wire sz = mra_ff[`ITE_MA_SZ];
  wire side_src = mra_ff[`ITE_MA_SIDE];
  // only the top two bits of the second mode byte are decoded
  wire chain = mrb_ff[`ITE_MB_CHN];
  wire keep_flag = mrb_ff[`ITE_MB_SEL];
  wire end_hit = (md == `ITE_MD_NORM) ? (cra_ff == 16'h0000) :
                 (md == `ITE_MD_BLK) ? (crb_ff == 16'h0000) : 1'b0;
  wire ap = hsel & htrans[1] & hready;
  // let a clear land before the next pick, else the same source fires again
  wire settle = flag_clr_ff | en_clr | sw_clr;

  // ----------------------------------------------------------------
  // arithmetic for one finished unit
  // ----------------------------------------------------------------
  always @* begin
    nxt_sar = ite_adv(sar_ff, sm, sz);
    nxt_dar = ite_adv(dar_ff, dm, sz);
    nxt_cra = cra_ff;
    nxt_crb = crb_ff;
    blk_more = 1'b0;
    if (md == `ITE_MD_NORM) begin
      nxt_cra = cra_ff - 16'h0001;
    end else begin
      nxt_cra = {cra_ff[15:8], cra_ff[7:0] - 8'h01};
      if (cra_ff[7:0] == 8'h01) begin
        nxt_cra = {cra_ff[15:8], cra_ff[15:8]};
        if (side_src) begin
          nxt_sar = ite_rew(nxt_sar, sm, sz, cra_ff[15:8]);
        end else begin
          nxt_dar = ite_rew(nxt_dar, dm, sz, cra_ff[15:8]);
        end
        if (md == `ITE_MD_BLK) begin
          nxt_crb = crb_ff - 16'h0001;
        end
      end else if (md == `ITE_MD_BLK) begin
        blk_more = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (~settle & (pick[6] | vec_ff[`ITE_VEC_SWE])) begin
          nxt_state = S_RA;
        end
      end
      S_RA: nxt_state = S_RB;
      S_RB: nxt_state = S_RC;
      S_RC: nxt_state = S_RD;
      S_RD: nxt_state = S_XR;
      S_XR: begin
        if (bus_ack) begin
          nxt_state = S_XW;
        end
      end
      S_XW: begin
        if (bus_ack) begin
          nxt_state = blk_more ? S_XR : S_WA;
        end
      end
      S_WA: nxt_state = S_WB;
      S_WB: nxt_state = S_WC;
      S_WC: nxt_state = S_FIN;
      S_FIN: nxt_state = chain ? S_RA : S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
    // stop freezes the sequencer wherever it stands
    if (stop) begin
      nxt_state = state_ff;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // descriptor and data path
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mra_ff <= 8'h00;
      mrb_ff <= 8'h00;
      sar_ff <= 24'h000000;
      dar_ff <= 24'h000000;
      cra_ff <= 16'h0000;
      crb_ff <= 16'h0000;
      dbase_ff <= `ITE_RAM_BASE;
      src_ff <= 6'h00;
      sw_ff <= 1'b0;
      data_ff <= 16'h0000;
      ram_addr_ff <= `ITE_RAM_BASE;
      ram_wdata_ff <= 32'h00000000;
      flag_clr_ff <= 1'b0;
      flag_id_ff <= 6'h00;
      en_clr <= 1'b0;
      sw_clr <= 1'b0;
    end else begin
      flag_clr_ff <= 1'b0;
      en_clr <= 1'b0;
      sw_clr <= 1'b0;
      if (!stop) begin
        case (state_ff)
          S_IDLE: begin
            if (pick[6]) begin
              src_ff <= pick[5:0];
              sw_ff <= 1'b0;
              dbase_ff <= `ITE_RAM_BASE | ({10'h000, pick[5:0]} << 4);
              ram_addr_ff <= `ITE_RAM_BASE | ({10'h000, pick[5:0]} << 4);
            end else begin
              src_ff <= vec_ff[5:0];
              sw_ff <= 1'b1;
              dbase_ff <= `ITE_RAM_BASE | ({10'h000, vec_ff[5:0]} << 4);
              ram_addr_ff <= `ITE_RAM_BASE | ({10'h000, vec_ff[5:0]} << 4);
            end
          end
          S_RA: begin
            ram_addr_ff <= dbase_ff + `ITE_WORD_STEP;
          end
          S_RB: begin
            mra_ff <= ram_rdata[31:24];
            sar_ff <= ram_rdata[23:0];
            ram_addr_ff <= dbase_ff + (`ITE_WORD_STEP << 1);
          end
          S_RC: begin
            mrb_ff <= ram_rdata[31:24];
            dar_ff <= ram_rdata[23:0];
          end
          S_RD: begin
            cra_ff <= ram_rdata[31:16];
            crb_ff <= ram_rdata[15:0];
          end
          S_XR: begin
            if (bus_ack) begin
              data_ff <= sz ? bus_rdata : {8'h00, bus_rdata[7:0]};
            end
          end
          S_XW: begin
            if (bus_ack) begin
              sar_ff <= nxt_sar;
              dar_ff <= nxt_dar;
              cra_ff <= nxt_cra;
              crb_ff <= nxt_crb;
              ram_addr_ff <= dbase_ff;
              ram_wdata_ff <= {mra_ff, nxt_sar};
            end
          end
          S_WA: begin
            ram_addr_ff <= dbase_ff + `ITE_WORD_STEP;
            ram_wdata_ff <= {mrb_ff, dar_ff};
          end
          S_WB: begin
            ram_addr_ff <= dbase_ff + (`ITE_WORD_STEP << 1);
            ram_wdata_ff <= {cra_ff, crb_ff};
          end
          S_FIN: begin
            if (chain) begin
              // next slot, wrapping inside the window
              dbase_ff <= `ITE_RAM_BASE |
                          ((dbase_ff + `ITE_DESC_STRIDE) & `ITE_RAM_MASK);
              ram_addr_ff <= `ITE_RAM_BASE |
                             ((dbase_ff + `ITE_DESC_STRIDE) & `ITE_RAM_MASK);
            end else begin
              // chained links never reach here, so no end check for them
              flag_clr_ff <= ~sw_ff & ~keep_flag & ~end_hit;
              flag_id_ff <= src_ff;
              en_clr <= ~sw_ff & (keep_flag | end_hit);
              sw_clr <= sw_ff & ~keep_flag & ~end_hit;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      aok_ff <= 1'b0;
      aidx_ff <= 16'h0000;
    end else begin
      wr_ff <= ap & hwrite;
      rd_ff <= ap & ~hwrite;
      if (ap) begin
        aok_ff <= (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'b00) & (hsize == 3'b010);
        aidx_ff <= haddr[17:2];
      end
    end
  end

  wire hit_en = aok_ff & (aidx_ff >= `ITE_IDX_EN0) & (aidx_ff <= `ITE_IDX_EN4);
  wire [15:0] en_off = aidx_ff - `ITE_IDX_EN0;
  wire [2:0] en_byte = en_off[2:0];
  wire hit_vec = aok_ff & (aidx_ff == `ITE_IDX_VEC);
  wire hit_sts = aok_ff & (aidx_ff == `ITE_IDX_STS);
  wire hit_mstp = aok_ff & (aidx_ff == `ITE_IDX_MSTP);

  // engine internals have no address; unmapped reads give zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_ff) begin
      hrdata_ff <= 32'h00000000;
      if (hit_en) begin
        hrdata_ff <= {24'h000000, en_ff[{en_byte, 3'b000} +: 8]};
      end else if (hit_vec) begin
        hrdata_ff <= {24'h000000, vec_ff};
      end else if (hit_sts) begin
        hrdata_ff <= {24'h000000, sw_ff, src_ff, state_ff != S_IDLE};
      end else if (hit_mstp) begin
        hrdata_ff <= {16'h0000, mstp_ff};
      end
    end
  end

  // ----------------------------------------------------------------
  // software visible registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_en
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          en_ff[g] <= 1'b0;
        end else if (wr_ff & hit_en & (en_byte == g / 8)) begin
          en_ff[g] <= hwdata[g % 8]; // a same cycle software write wins
        end else if (en_clr & (src_ff == g)) begin
          en_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_ff <= `ITE_VEC_RST;
      arm_ff <= 1'b0;
      mstp_ff <= `ITE_MSTP_RST;
    end else begin
      if (sw_clr) begin
        vec_ff[`ITE_VEC_SWE] <= 1'b0;
      end
      if (rd_ff & hit_vec & vec_ff[`ITE_VEC_SWE]) begin
        arm_ff <= 1'b1;
      end
      if (wr_ff & hit_vec) begin
        vec_ff[6:0] <= hwdata[6:0];
        arm_ff <= 1'b0;
        // one always sets; zero only clears after a read of one
        if (hwdata[`ITE_VEC_SWE]) begin
          vec_ff[`ITE_VEC_SWE] <= 1'b1;
        end else if (arm_ff) begin
          vec_ff[`ITE_VEC_SWE] <= 1'b0;
        end
      end
      if (wr_ff & hit_mstp) begin
        mstp_ff <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = ~rd_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign flag_clr = flag_clr_ff;
  assign flag_clr_id = flag_id_ff;
  assign ram_en = ~stop & ((state_ff >= S_RA & state_ff <= S_RC) |
                           (state_ff >= S_WA & state_ff <= S_WC));
  assign ram_we = ~stop & (state_ff >= S_WA) & (state_ff <= S_WC);
  assign ram_addr = ram_addr_ff;
  assign ram_wdata = ram_wdata_ff;
  assign bus_req = ~stop & ((state_ff == S_XR) | (state_ff == S_XW));
  assign bus_we = (state_ff == S_XW);
  assign bus_size = sz;
  assign bus_addr = (state_ff == S_XW) ? dar_ff : sar_ff;
  assign bus_wdata = data_ff;

endmodule
`default_nettype wire

// *** tb/ite_engine_sva.sv ***
// Purpose: port checker for the transfer engine
// Assumes: bound to ite_engine, one clock domain
// Notes: watches ahb answers, ram bursts and bus handshake
`timescale 1ns/1ps
`default_nettype none
module ite_engine_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic flag_clr,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire logic bus_we,
  input wire logic [23:0] bus_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  ahb_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  ram_window_a: assert property (ram_en |-> ram_addr[15:10] == 6'b111110)
    else $error("ram access outside window");
  ram_burst_a: assert property ($rose(ram_en) |-> ram_en [*3])
    else $error("descriptor burst short");
  ram_stride_a: assert property (ram_en && $past(ram_en) && ram_we == $past(ram_we)
    && ram_addr[3:2] != 2'b00 |-> ram_addr == $past(ram_addr) + 16'h0004)
    else $error("descriptor word stride wrong");
  ram_write_a: assert property (ram_we |-> ram_en)
    else $error("ram write without enable");
  bus_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
    && $stable(bus_we))
    else $error("bus request dropped early");
  flag_pulse_a: assert property (flag_clr |=> !flag_clr)
    else $error("flag clear longer than a cycle");
endmodule
bind ite_engine ite_engine_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .flag_clr, .ram_en, .ram_we, .ram_addr, .bus_req, .bus_ack, .bus_we,
  .bus_addr);
`default_nettype wire

// *** tb/ite_far_model.sv ***
// Purpose: descriptor ram and system bus slave facing the engine
// Assumes: ram enable kept set by software
// Notes: idle read lines toggle so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module ite_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] ack_delay,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  output logic [31:0] ram_rdata,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [23:0] bus_addr,
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_cnt;
  // ram always on, one state per word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_rdata <= 32'h0;
    end else begin
      if (ram_en && ram_we)
        mem[ram_addr[9:2]] <= ram_wdata;
      ram_rdata <= (ram_en && !ram_we) ? mem[ram_addr[9:2]] : ~ram_rdata;
    end
  end
  // ack after a programmable stall
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0;
    end else if (bus_req && !bus_ack && wait_cnt >= ack_delay) begin
      bus_ack <= 1'b1;
      wait_cnt <= 4'h0;
      bus_rdata <= bus_we ? ~bus_rdata : bus_addr[15:0] ^ 16'h5a5a;
    end else begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_cnt <= (bus_req && !bus_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the transfer engine
// Assumes: far model holds ram and bus, bench plays cpu and irq source
// Notes: each test but t_regs loads descriptors, activates, checks write back; all but t_regs and t_stop check bus
`timescale 1ns/1ps
`default_nettype none
`include "ite_defines.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [39:0] irq_req = 40'h0;
  logic [3:0] ack_delay = 4'h0;
  wire logic hreadyout, hresp, flag_clr, ram_en, ram_we, bus_req, bus_we, bus_size, bus_ack;
  wire logic [5:0] flag_clr_id;
  wire logic [15:0] ram_addr, bus_wdata, bus_rdata;
  wire logic [31:0] hrdata, ram_wdata, ram_rdata;
  wire logic [23:0] bus_addr;
  int bad_count = 0;
  int comparisons = 0;
  int wb_n = 0;
  int ram_n = 0;
  int fl_n = 0;
  int base, f0, n0;
  logic [5:0] fl_id;
  logic [25:0] log_q[$];
  logic [25:0] exp_q[$];
  logic [15:0] wd_q[$];
  logic [31:0] rd;
  always #25 hclk = ~hclk;
  ite_engine DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_req, .flag_clr, .flag_clr_id,
    .ram_en, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .bus_req, .bus_we, .bus_size,
    .bus_addr, .bus_wdata, .bus_rdata, .bus_ack);
  ite_far_model pm (.hclk, .hresetn, .ack_delay, .ram_en, .ram_we, .ram_addr, .ram_wdata,
    .ram_rdata, .bus_req, .bus_we, .bus_addr, .bus_rdata, .bus_ack);
  // ----------------------------------------
  // monitor, irq source drops on flag clear
  // ----------------------------------------
  always @(posedge hclk) begin
    if (bus_req && bus_ack) begin
      log_q.push_back({bus_we, bus_size, bus_addr});
      if (bus_we)
        wd_q.push_back(bus_wdata);
    end
    if (ram_en)
      ram_n++;
    if (ram_en && ram_we)
      wb_n++;
    if (flag_clr) begin
      fl_n++;
      fl_id = flag_clr_id;
      irq_req[flag_clr_id] <= 1'b0;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task ahb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    ahb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask
  task desc(input int s, input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
    pm.mem[s * 4] = w0;
    pm.mem[s * 4 + 1] = w1;
    pm.mem[s * 4 + 2] = w2;
  endtask
  task ex(input logic w, input logic s, input logic [23:0] a);
    exp_q.push_back({w, s, a});
  endtask
  task wait_wb(input int n);
    int k;
    k = 0;
    while (wb_n < n && k < 400) begin
      @(posedge hclk);
      k++;
    end
    chk("write back done", 32'h1, {31'h0, k < 400});
    repeat (4) @(posedge hclk);
  endtask
  task chk_log;
    chk("bus cycle count", exp_q.size(), log_q.size());
    foreach (exp_q[i]) begin
      if (i < log_q.size())
        chk("bus cycle", {6'h0, exp_q[i]}, {6'h0, log_q[i]});
    end
    exp_q.delete();
    log_q.delete();
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  task t_regs;
    rdchk(`ITE_IDX_EN0, 32'h0, "enable bank");
    rdchk(`ITE_IDX_VEC, 32'h0, "vector reg");
    rdchk(`ITE_IDX_MSTP, 32'h3fff, "module stop");
    ahb(1'b1, `ITE_IDX_EN4, 32'h5a);
    rdchk(`ITE_IDX_EN4, 32'h5a, "enable byte 4");
    ahb(1'b1, `ITE_IDX_EN4, 32'h0);
    ahb(1'b1, 16'hff35, 32'hff);
    rdchk(16'hff35, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task t_soft;
    desc(2, {8'h80, 24'h001000}, {8'h00, 24'h002000}, 32'h00030000);
    base = wb_n;
    ahb(1'b1, `ITE_IDX_VEC, 32'h82);
    wait_wb(base + 3);
    ex(1'b0, 1'b0, 24'h001000);
    ex(1'b1, 1'b0, 24'h002000);
    chk_log;
    chk("src pointer", {8'h80, 24'h001001}, pm.mem[8]);
    chk("dst pointer", {8'h00, 24'h002000}, pm.mem[9]);
    chk("count", 32'h00020000, pm.mem[10]);
    rdchk(`ITE_IDX_VEC, 32'h02, "software start");
    $display("test software start done");
  endtask
  task t_repeat;
    ack_delay <= 4'h3;
    desc(5, {8'he5, 24'h003010}, {8'h40, 24'h004000}, 32'h01010000);
    ahb(1'b1, `ITE_IDX_EN0, 32'h20);
    base = wb_n;
    f0 = fl_n;
    irq_req[5] <= 1'b1;
    wait_wb(base + 3);
    ex(1'b0, 1'b1, 24'h003010);
    ex(1'b1, 1'b1, 24'h004000);
    chk_log;
    chk("word data", 32'h6a4a, {16'h0, wd_q.pop_back()});
    chk("src pointer", {8'he5, 24'h00300e}, pm.mem[20]);
    chk("dst rewound", {8'h40, 24'h004000}, pm.mem[21]);
    chk("count reload", 32'h01010000, pm.mem[22]);
    chk("no flag clear", 32'h0, fl_n - f0);
    rdchk(`ITE_IDX_EN0, 32'h0, "enable cleared");
    irq_req[5] <= 1'b0;
    $display("test repeat done");
  endtask
  task t_chain;
    ack_delay <= 4'h1;
    desc(9, {8'haa, 24'h005000}, {8'h80, 24'h006000}, 32'h02020001);
    desc(10, {8'h30, 24'h007000}, {8'h00, 24'h008000}, 32'h00010000);
    ahb(1'b1, 16'hff31, 32'h02);
    base = wb_n;
    f0 = fl_n;
    irq_req[9] <= 1'b1;
    wait_wb(base + 6);
    ex(1'b0, 1'b0, 24'h005000);
    ex(1'b1, 1'b0, 24'h006000);
    ex(1'b0, 1'b0, 24'h005001);
    ex(1'b1, 1'b0, 24'h006001);
    ex(1'b0, 1'b0, 24'h007000);
    ex(1'b1, 1'b0, 24'h008000);
    chk_log;
    chk("block side rewound", {8'haa, 24'h005000}, pm.mem[36]);
    chk("dst pointer", {8'h80, 24'h006002}, pm.mem[37]);
    chk("block counts", 32'h02020000, pm.mem[38]);
    chk("chained count", 32'h0, pm.mem[42]);
    chk("dst decrement", {8'h00, 24'h007fff}, pm.mem[41]);
    chk("no flag clear", 32'h0, fl_n - f0);
    n0 = ram_n;
    repeat (20) @(posedge hclk);
    chk("idle after end", n0, ram_n);
    rdchk(16'hff31, 32'h0, "enable cleared");
    irq_req[9] <= 1'b0;
    $display("test chain done");
  endtask
  task t_stop;
    ack_delay <= 4'h0;
    desc(0, {8'h00, 24'h009000}, {8'h00, 24'h00a000}, 32'h00050000);
    ahb(1'b1, `ITE_IDX_MSTP, 32'h7fff);
    ahb(1'b1, `ITE_IDX_EN0, 32'h01);
    n0 = ram_n;
    irq_req[0] <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("halted", n0, ram_n);
    base = wb_n;
    f0 = fl_n;
    ahb(1'b1, `ITE_IDX_MSTP, 32'h3fff);
    wait_wb(base + 3);
    chk("flag clears", 32'h1, fl_n - f0);
    chk("flag source", 32'h0, {26'h0, fl_id});
    chk("count", 32'h00040000, pm.mem[2]);
    rdchk(`ITE_IDX_EN0, 32'h01, "enable kept");
    $display("test module stop done");
  endtask
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    $display("watchdog expired");
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_soft;
    t_repeat;
    t_chain;
    t_stop;
    report_and_stop;
  end
endmodule
`default_nettype wire
